// *** rtl/smcr_pkg.sv ***
// Constants and types of the static memory command register bank
package smcr_pkg;
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned INIT_NS       = 320;
    localparam int unsigned INIT_CYC      = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MODE_WR_NS    = 100;
    localparam int unsigned MODE_WR_CYC   = (MODE_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 5;

    // Bus geometry
    localparam int unsigned AW     = 13;
    localparam int unsigned CHIPS  = 4;
    localparam int unsigned CYC_W  = 20;
    localparam int unsigned OPM_W  = 16;
    localparam int unsigned IRQ_W  = 5;

    // Register byte offsets
    localparam logic [12:0] OFS_STATUS   = 13'h1000;
    localparam logic [12:0] OFS_CFG_SET  = 13'h1008;
    localparam logic [12:0] OFS_CFG_CLR  = 13'h100C;
    localparam logic [12:0] OFS_DIR_CMD  = 13'h1010;
    localparam logic [12:0] OFS_HOLD_CYC = 13'h1014;
    localparam logic [12:0] OFS_HOLD_OPM = 13'h1018;
    localparam logic [12:0] OFS_IRQ_STAT = 13'h1030;
    localparam logic [12:0] OFS_IRQ_MASK = 13'h1034;
    localparam logic [4:0]  WORK_PAGE    = 5'h11;
    localparam logic [4:0]  WORK_CYC_OFS = 5'h00;
    localparam logic [4:0]  WORK_OPM_OFS = 5'h04;

    // Field positions
    localparam int unsigned CFG_IRQ_BIT  = 0;
    localparam int unsigned CFG_LP_BIT   = 2;
    localparam int unsigned CMD_CHIP_HI  = 25;
    localparam int unsigned CMD_CHIP_LO  = 23;
    localparam int unsigned CMD_KIND_HI  = 22;
    localparam int unsigned CMD_KIND_LO  = 21;
    localparam int unsigned CMD_CRE_BIT  = 20;
    localparam int unsigned CMD_ADDR_HI  = 19;
    localparam int unsigned CMD_BUS_HI   = 15;
    localparam int unsigned HOLD_CYC_HI  = 22;
    localparam int unsigned ST_STATE_BIT = 0;
    localparam int unsigned ST_IRQ_BIT   = 1;

    // Reset values
    localparam logic [19:0] WORK_CYC_RST = 20'h2B3CC;
    localparam logic [15:0] WORK_OPM_RST = 16'h0802;
    localparam logic [22:0] HOLD_CYC_RST = 23'h002B3CC;

    // Interrupt event bits
    localparam int unsigned EV_CMD_DONE = 0;
    localparam int unsigned EV_LP_ENTER = 1;
    localparam int unsigned EV_LP_EXIT  = 2;
    localparam int unsigned EV_CMD_BAD  = 3;
    localparam int unsigned EV_IF0_INT  = 4;

    // Command kinds
    localparam logic [1:0] KIND_UPD_BUS  = 2'h0;
    localparam logic [1:0] KIND_MODE     = 2'h1;
    localparam logic [1:0] KIND_UPD      = 2'h2;
    localparam logic [1:0] KIND_MODE_UPD = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] { ST_RESET, ST_READY, ST_LOWPWR } smcr_state_e;
endpackage

// *** rtl/smcr_regs.sv ***
// Command register bank of the static memory controller with AXI4-Lite slave
//
// Overview of operation
// - Set register bit 2 at one requests low power, entered when next idle.
// - Set register bit 0 at one enables interface 0 interrupt; zero ignored.
// - Clear register bit 2 at one requests leaving low power; zero ignored.
// - Clear register bit 0 at one disables interface 0 interrupt; zero ignored.
// - Set and clear registers refuse writes in reset state.
// - Direct command and timing holding refuse writes in reset or low power.
// - Chip field 25:23 selects chips 1-4 for 0-3; 4-7 reserved.
// - Kind field 22:21: update+bus, mode write, update, mode write+update.
// - Update copies held timing and opmode into selected chip working registers.
// - Configuration enable output follows bit 20 during a mode write.
// - Mode command drives address field 19:0 onto memory address 19:0.
// - Update plus bus command passes bits 15:0 as bus data.
// - Holding register keeps read cycle 3:0 and write cycle 7:4.
// - Holding keeps 3-bit delay, pulse, page, turnaround; 22:20 reserved.
// - Status bit 0 reports ready as zero, low power as one.
// - Status bit 1 reports the interface 0 interrupt enable.
`timescale 1ns/1ps
`default_nettype none
module smcr_regs
    import smcr_pkg::*;
(
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    input  wire logic [AW-1:0]                s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output var  logic                         s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output var  logic                         s_axi_wready,
    output var  logic [1:0]                   s_axi_bresp,
    output var  logic                         s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [AW-1:0]                s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output var  logic                         s_axi_arready,
    output var  logic [31:0]                  s_axi_rdata,
    output var  logic [1:0]                   s_axi_rresp,
    output var  logic                         s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic                         ext_busy,
    input  wire logic                         if0_int_pin,
    output var  logic                         irq,
    output var  logic                         lp_state,
    output var  logic [19:0]                  mem_addr,
    output var  logic                         mem_cre,
    output var  logic                         mem_mode_write,
    output var  logic [1:0]                   mem_chip,
    output var  logic                         bus_cmd_valid,
    output var  logic [15:0]                  bus_cmd_data,
    output var  logic [CHIPS-1:0][CYC_W-1:0]  work_cycles,
    output var  logic [CHIPS-1:0][OPM_W-1:0]  work_opmode
);

    function automatic logic kind_updates(input logic [1:0] k);
        kind_updates = (k != KIND_MODE);
    endfunction

    function automatic logic kind_mode(input logic [1:0] k);
        kind_mode = (k == KIND_MODE) || (k == KIND_MODE_UPD);
    endfunction

    // Controller state and counters
    smcr_state_e                 state_r;
    logic [CNT_W-1:0]            init_cnt_r;
    logic [CNT_W-1:0]            mode_cnt_r;
    logic                        lp_req_r;
    logic                        irq_on_state_r;
    logic [22:0]                 hold_cyc_r;
    logic [OPM_W-1:0]            hold_opm_r;
    logic [IRQ_W-1:0]            irq_stat_r;
    logic [IRQ_W-1:0]            irq_mask_r;
    logic [1:0]                  int_sync_r;
    logic                        int_prev_r;

    // Write channel capture
    logic                        aw_have_r;
    logic                        w_have_r;
    logic [AW-1:0]               wa_r;
    logic [31:0]                 wd_r;
    logic [3:0]                  ws_r;

    // Write decode
    wire logic        wr_fire  = aw_have_r && w_have_r && !s_axi_bvalid;
    wire logic [31:0] wmask    = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
    wire logic [31:0] wd       = wd_r & wmask;
    wire logic        in_reset = (state_r == ST_RESET);
    wire logic        in_lp    = (state_r == ST_LOWPWR);
    wire logic        hit_set  = (wa_r == OFS_CFG_SET);
    wire logic        hit_clr  = (wa_r == OFS_CFG_CLR);
    wire logic        hit_cmd  = (wa_r == OFS_DIR_CMD);
    wire logic        hit_hcyc = (wa_r == OFS_HOLD_CYC);
    wire logic        hit_hopm = (wa_r == OFS_HOLD_OPM);
    wire logic        hit_ist  = (wa_r == OFS_IRQ_STAT);
    wire logic        hit_imsk = (wa_r == OFS_IRQ_MASK);
    wire logic        wr_known = hit_set || hit_clr || hit_cmd || hit_hcyc || hit_hopm
                                 || hit_ist || hit_imsk;
    wire logic        cfg_gate = in_reset && (hit_set || hit_clr);
    wire logic        cmd_gate = (in_reset || in_lp) && (hit_cmd || hit_hcyc || hit_hopm);
    wire logic        seq_busy = (mode_cnt_r != '0);
    wire logic        cmd_hold = hit_cmd && seq_busy;
    wire logic        wr_ok    = wr_fire && wr_known && !cfg_gate && !cmd_gate && !cmd_hold;
    wire logic [1:0]  wr_resp  = !wr_known ? RESP_DECERR :
                                 (cfg_gate || cmd_gate || cmd_hold) ? RESP_SLVERR : RESP_OKAY;

    // Command decode
    wire logic [2:0]  cmd_chip = wd[CMD_CHIP_HI:CMD_CHIP_LO];
    wire logic [1:0]  cmd_kind = wd[CMD_KIND_HI:CMD_KIND_LO];
    wire logic        cmd_go   = wr_ok && hit_cmd;
    wire logic        cmd_bad  = cmd_go && cmd_chip[2];
    wire logic        upd_go   = cmd_go && !cmd_chip[2] && kind_updates(cmd_kind);
    wire logic        mode_go  = cmd_go && !cmd_chip[2] && kind_mode(cmd_kind);
    wire logic        bus_go   = cmd_go && !cmd_chip[2] && (cmd_kind == KIND_UPD_BUS);
    wire logic        mode_end = (mode_cnt_r == CNT_W'(1));
    wire logic        set_lp   = wr_ok && hit_set && wd[CFG_LP_BIT];
    wire logic        clr_lp   = wr_ok && hit_clr && wd[CFG_LP_BIT];
    wire logic        set_ien  = wr_ok && hit_set && wd[CFG_IRQ_BIT];
    wire logic        clr_ien  = wr_ok && hit_clr && wd[CFG_IRQ_BIT];
    wire logic        idle     = !seq_busy && !ext_busy && !mode_go;
    wire logic        lp_enter = (state_r == ST_READY) && lp_req_r && idle;
    wire logic        lp_exit  = in_lp && clr_lp;
    wire logic        int_edge = int_sync_r[1] && !int_prev_r;

    // Events and interrupt status
    wire logic [IRQ_W-1:0] events = {int_edge && irq_on_state_r, cmd_bad, lp_exit, lp_enter,
                                     (upd_go && !mode_go) || mode_end};
    wire logic [IRQ_W-1:0] w1c    = (wr_ok && hit_ist) ? wd[IRQ_W-1:0] : '0;
    wire logic [IRQ_W-1:0] stat_nxt = (irq_stat_r & ~w1c) | events;

    // Read decode
    wire logic        rd_work  = (s_axi_araddr[12:8] == WORK_PAGE) && !s_axi_araddr[7];
    wire logic [1:0]  rd_bank  = s_axi_araddr[6:5];
    wire logic        rd_wcyc  = rd_work && (s_axi_araddr[4:0] == WORK_CYC_OFS);
    wire logic        rd_wopm  = rd_work && (s_axi_araddr[4:0] == WORK_OPM_OFS);
    wire logic        rd_stat  = (s_axi_araddr == OFS_STATUS);
    wire logic        rd_wo    = (s_axi_araddr == OFS_CFG_SET) || (s_axi_araddr == OFS_CFG_CLR)
                                 || (s_axi_araddr == OFS_DIR_CMD)
                                 || (s_axi_araddr == OFS_HOLD_CYC)
                                 || (s_axi_araddr == OFS_HOLD_OPM);
    wire logic [31:0] status_w = {30'h0, irq_on_state_r, in_lp};
    wire logic [31:0] rd_data  =
        rd_stat && !in_reset            ? status_w :
        (s_axi_araddr == OFS_IRQ_STAT)  ? {27'h0, irq_stat_r} :
        (s_axi_araddr == OFS_IRQ_MASK)  ? {27'h0, irq_mask_r} :
        rd_wcyc                         ? {12'h0, work_cycles[rd_bank]} :
        rd_wopm                         ? {16'h0, work_opmode[rd_bank]} : 32'h0;
    wire logic        rd_known = rd_stat || rd_wo || rd_wcyc || rd_wopm
                                 || (s_axi_araddr == OFS_IRQ_STAT)
                                 || (s_axi_araddr == OFS_IRQ_MASK);
    wire logic [1:0]  rd_resp  = !rd_known ? RESP_DECERR :
                                 (rd_wo || (rd_stat && in_reset)) ? RESP_SLVERR : RESP_OKAY;

    // Write address and data capture, write response
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            wa_r          <= '0;
            wd_r          <= 32'h0;
            ws_r          <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r     <= 1'b1;
                wa_r          <= {s_axi_awaddr[AW-1:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r     <= 1'b1;
                wd_r         <= s_axi_wdata;
                ws_r         <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_resp;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Controller state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= ST_RESET;
            init_cnt_r <= CNT_W'(INIT_CYC);
            lp_req_r   <= 1'b0;
        end else begin
            case (state_r)
                ST_RESET: begin
                    init_cnt_r <= init_cnt_r - CNT_W'(1);
                    if (init_cnt_r == CNT_W'(1)) begin
                        state_r <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (lp_enter) begin
                        state_r <= ST_LOWPWR;
                    end
                end
                ST_LOWPWR: begin
                    if (lp_exit) begin
                        state_r <= ST_READY;
                    end
                end
                default: state_r <= ST_RESET;
            endcase
            if (lp_enter || clr_lp) begin
                lp_req_r <= 1'b0;
            end else if (set_lp) begin
                lp_req_r <= 1'b1;
            end
        end
    end

    // Interrupt enable, held values and working registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_on_state_r <= 1'b0;
            hold_cyc_r     <= HOLD_CYC_RST;
            hold_opm_r     <= WORK_OPM_RST;
            work_cycles    <= {CHIPS{WORK_CYC_RST}};
            work_opmode    <= {CHIPS{WORK_OPM_RST}};
        end else begin
            if (set_ien) begin
                irq_on_state_r <= 1'b1;
            end else if (clr_ien) begin
                irq_on_state_r <= 1'b0;
            end
            if (wr_ok && hit_hcyc) begin
                hold_cyc_r <= wd[HOLD_CYC_HI:0];
            end
            if (wr_ok && hit_hopm) begin
                hold_opm_r <= wd[OPM_W-1:0];
            end
            if (upd_go) begin
                work_cycles[cmd_chip[1:0]] <= hold_cyc_r[CYC_W-1:0];
                work_opmode[cmd_chip[1:0]] <= hold_opm_r;
            end
        end
    end

    // Mode register write and bus command outputs
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_cnt_r     <= '0;
            mem_addr       <= 20'h0;
            mem_cre        <= 1'b0;
            mem_mode_write <= 1'b0;
            mem_chip       <= 2'h0;
            bus_cmd_valid  <= 1'b0;
            bus_cmd_data   <= 16'h0;
        end else begin
            bus_cmd_valid <= bus_go;
            if (bus_go) begin
                bus_cmd_data <= wd[CMD_BUS_HI:0];
                mem_chip     <= cmd_chip[1:0];
            end
            if (mode_go) begin
                mode_cnt_r     <= CNT_W'(MODE_WR_CYC);
                mem_addr       <= wd[CMD_ADDR_HI:0];
                mem_cre        <= wd[CMD_CRE_BIT];
                mem_mode_write <= 1'b1;
                mem_chip       <= cmd_chip[1:0];
            end else if (seq_busy) begin
                mode_cnt_r <= mode_cnt_r - CNT_W'(1);
                if (mode_end) begin
                    mem_mode_write <= 1'b0;
                    mem_cre        <= 1'b0;
                end
            end
        end
    end

    // Interrupt pin synchroniser, status and output
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            int_sync_r <= 2'b00;
            int_prev_r <= 1'b0;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq        <= 1'b0;
            lp_state   <= 1'b0;
        end else begin
            int_sync_r <= {int_sync_r[0], if0_int_pin};
            int_prev_r <= int_sync_r[1];
            irq_stat_r <= stat_nxt;
            if (wr_ok && hit_imsk) begin
                irq_mask_r <= wd[IRQ_W-1:0];
            end
            irq      <= |(stat_nxt & ((wr_ok && hit_imsk) ? wd[IRQ_W-1:0] : irq_mask_r));
            lp_state <= (state_r == ST_LOWPWR) ? !lp_exit : lp_enter;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_set_irq_on: assert property (
        set_ien |=> irq_on_state_r && s_axi_bvalid && (s_axi_bresp == RESP_OKAY))
        else $error("interrupt enable not set by set register");

    chk_clr_irq_off: assert property (
        (clr_ien && !set_ien) |=> !irq_on_state_r)
        else $error("interrupt enable not cleared by clear register");

    chk_reset_refuse: assert property (
        (wr_fire && in_reset && (hit_set || hit_clr))
            |=> (s_axi_bresp == RESP_SLVERR) && $stable(irq_on_state_r) && !lp_req_r)
        else $error("configuration write taken in reset state");

    chk_lp_hold_gate: assert property (
        (wr_fire && in_lp && (hit_hcyc || hit_cmd))
            |=> $stable(hold_cyc_r) && !mem_mode_write && (s_axi_bresp == RESP_SLVERR))
        else $error("command or holding write taken in low power");

    chk_lp_entry: assert property (
        (state_r == ST_READY && lp_req_r && !seq_busy && !ext_busy && !mode_go)
            |=> in_lp ##0 lp_state && !lp_req_r)
        else $error("low power not entered when idle");

    chk_lp_exit: assert property (
        (in_lp && clr_lp) |=> (state_r == ST_READY) && !lp_state)
        else $error("low power not left on request");

    chk_mode_length: assert property (
        $rose(mem_mode_write) |-> mem_mode_write[*5] ##1 !mem_mode_write && !mem_cre)
        else $error("mode write length wrong");

    chk_mode_fields: assert property (
        mode_go |=> mem_mode_write && (mem_cre == $past(wd_r[CMD_CRE_BIT]))
            && (mem_addr == $past(wd_r[CMD_ADDR_HI:0])))
        else $error("mode write address or enable wrong");

    chk_cre_quiet: assert property (
        !mem_mode_write |-> !mem_cre)
        else $error("configuration enable high outside mode write");

    chk_update_copy: assert property (
        upd_go |=> (work_cycles[$past(cmd_chip[1:0])] == $past(hold_cyc_r[CYC_W-1:0]))
            && $stable(hold_cyc_r) && $stable(hold_opm_r))
        else $error("update did not copy held values");

    chk_reserved_chip: assert property (
        cmd_bad |=> $stable(work_cycles) && !mem_mode_write && irq_stat_r[EV_CMD_BAD])
        else $error("reserved chip select acted on");

    chk_status_bits: assert property (
        (s_axi_arvalid && s_axi_arready && rd_stat && !in_reset)
            |=> (s_axi_rdata[ST_IRQ_BIT] == $past(irq_on_state_r))
            && (s_axi_rdata[ST_STATE_BIT] == $past(in_lp)))
        else $error("status read wrong");

endmodule
`default_nettype wire

// *** test/smcr_mem_model.sv ***
// External memory model watching mode writes and bus commands
`timescale 1ns/1ps
`default_nettype none
module smcr_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        stall,
    input  wire logic [19:0] mem_addr,
    input  wire logic        mem_cre,
    input  wire logic        mem_mode_write,
    input  wire logic [1:0]  mem_chip,
    input  wire logic        bus_cmd_valid,
    input  wire logic [15:0] bus_cmd_data,
    output var  logic        ext_busy,
    output var  logic        if0_int_pin
);
    logic [19:0] seen_addr;
    logic [15:0] seen_data;
    logic [1:0]  seen_chip;
    logic        seen_cre;
    logic [7:0]  run = 8'h00;
    logic [7:0]  seen_len;
    assign ext_busy = stall;
    always @(posedge clk_sys) begin
        if0_int_pin <= $fell(mem_mode_write);
        run <= mem_mode_write ? run + 8'h01 : 8'h00;
        if (!mem_mode_write && run != 8'h00) seen_len <= run;
        if (bus_cmd_valid) seen_data <= bus_cmd_data;
        if (mem_mode_write) begin
            seen_addr <= mem_addr;
            seen_cre <= mem_cre;
            seen_chip <= mem_chip;
        end
    end
endmodule
`default_nettype wire

// *** test/test_smcr_regs.sv ***
// Bench for the command register bank over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module test_smcr_regs
    import smcr_pkg::*;
;
    localparam logic [31:0] HV = 32'h00094A7B;
    logic                        clk_sys = 1'h0, sys_rst = 1'h1, stall = 1'h0;
    logic [AW-1:0]               s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0]                  s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0]                 s_axi_wdata = '0, s_axi_rdata, rv;
    logic [3:0]                  s_axi_wstrb = 4'hF;
    logic                        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic                        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic                        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic                        s_axi_rvalid, ext_busy, if0_int_pin, irq, lp_state, mem_cre;
    logic                        mem_mode_write, bus_cmd_valid;
    logic [1:0]                  s_axi_bresp, s_axi_rresp, mem_chip, rsp;
    logic [19:0]                 mem_addr;
    logic [15:0]                 bus_cmd_data;
    logic [CHIPS-1:0][CYC_W-1:0] work_cycles;
    logic [CHIPS-1:0][OPM_W-1:0] work_opmode;
    int                          n_fail = 0, compares = 0;
    smcr_regs i_smcr_regs (.*);
    smcr_mem_model i_smcr_mem_model (.*);
    always #10 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask
    task automatic rd(input logic [12:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rsp = s_axi_rresp;
        rv = s_axi_rdata;
    endtask
    task automatic status(input logic [31:0] exp);
        rd(OFS_STATUS);
        chk(rv, exp, "status");
    endtask
    task automatic print_verdict;
        $display("Counts: %0d compares, %0d failures", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'h0;
        wr(OFS_CFG_SET, 32'h00000001);
        chk(rsp, RESP_SLVERR, "set in reset");
        wr(OFS_DIR_CMD, 32'h01400000);
        chk(rsp, RESP_SLVERR, "cmd in reset");
        repeat (20) @(posedge clk_sys);
        status(32'h0);
        $display("test reset done");
        wr(OFS_CFG_SET, 32'h0);
        status(32'h0);
        wr(OFS_CFG_SET, 32'h1);
        status(32'h2);
        wr(OFS_CFG_CLR, 32'h0);
        status(32'h2);
        wr(OFS_CFG_CLR, 32'h1);
        status(32'h0);
        $display("test irq enable done");
        wr(OFS_HOLD_CYC, HV);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_DIR_CMD, {7'h00, k[1:0], k[1:0], k[1], 16'hA500, 2'h0, k[1:0]});
            chk(rsp, RESP_OKAY, "cmd resp");
            repeat (8) @(posedge clk_sys);
            chk(work_cycles[k], (k == 1) ? WORK_CYC_RST : HV[19:0], "work");
            if (k == 0) chk(i_smcr_mem_model.seen_data, 16'h5000, "bus data");
            if (k[0]) begin
                chk(i_smcr_mem_model.seen_addr, {16'hA500, 2'h0, k[1:0]}, "addr");
                chk(i_smcr_mem_model.seen_cre, k[1], "cre");
                chk(i_smcr_mem_model.seen_chip, k[1:0], "chip");
                chk(i_smcr_mem_model.seen_len, MODE_WR_CYC, "mode len");
            end
        end
        chk(mem_cre, 1'h0, "cre idle");
        wr(OFS_HOLD_CYC, 32'h00011111);
        wr(OFS_DIR_CMD, {6'h00, 3'h4, KIND_UPD, 21'h0});
        repeat (4) @(posedge clk_sys);
        chk(work_cycles[0], HV[19:0], "reserved chip");
        chk(work_opmode[0], WORK_OPM_RST, "opmode");
        $display("test commands done");
        wr(OFS_HOLD_OPM, 32'h00001234);
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_IRQ_STAT, 32'h1F);
        wr(OFS_DIR_CMD, {6'h00, 3'h0, KIND_UPD, 21'h0});
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'h0, "irq masked");
        chk(work_opmode[0], 16'h1234, "opmode copy");
        chk(work_cycles[0], 20'h11111, "cycles copy");
        wr(OFS_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'h1, "irq raised");
        wr(OFS_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'h0, "irq cleared");
        $display("test interrupt done");
        stall <= 1'h1;
        wr(OFS_CFG_SET, 32'h4);
        repeat (5) @(posedge clk_sys);
        status(32'h0);
        stall <= 1'h0;
        repeat (5) @(posedge clk_sys);
        status(32'h1);
        chk(lp_state, 1'h1, "lp pin");
        wr(OFS_HOLD_CYC, 32'h0);
        chk(rsp, RESP_SLVERR, "hold in low power");
        wr(OFS_DIR_CMD, 32'h0);
        chk(rsp, RESP_SLVERR, "cmd in low power");
        wr(OFS_CFG_CLR, 32'h4);
        repeat (3) @(posedge clk_sys);
        status(32'h0);
        chk(lp_state, 1'h0, "lp pin off");
        rd(OFS_IRQ_STAT);
        chk(rv, 32'h6, "lp events");
        rd(13'h1FFC);
        chk(rsp, RESP_DECERR, "unmapped");
        $display("test low power done");
        print_verdict();
    end
endmodule
`default_nettype wire
